/* File: eeprom_access_control.sv */
// Control and status logic for indirect access to a 256-byte data EEPROM.
// Assumes an AXI4-Lite master on clk; Flash and configuration cycles are only timed here.
`timescale 1ns/10ps
module eeprom_access_control #(
  parameter int PROG_CYCLES = nvm_access_pkg::PROG_CYCLES_DEF,
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic progBusy,
  output logic flashEraseStrobe,
  output logic [nvm_access_pkg::TPTR_W-1:0] flashRowAddr,
  output logic irq
);
  nvm_access_pkg::ctrl_t ctrl_reg, ctrl_next;
  nvm_access_pkg::prog_state_t state_reg, state_next;
  logic [7:0] index_reg;
  logic [7:0] buffer_reg, buffer_next;
  logic [nvm_access_pkg::TPTR_W-1:0] tptr_reg;
  logic [nvm_access_pkg::IRQ_W-1:0] irqStat_reg, irqStat_next, irqMask_reg;
  logic [31:0] count_reg;
  logic [7:0] eeprom [DEPTH];
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic rstPrev_reg;

  // Merges written bytes under the byte strobes into an old word
  function automatic logic [31:0] strobeMerge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return a == nvm_access_pkg::OFS_CONTROL || a == nvm_access_pkg::OFS_INDEX ||
           a == nvm_access_pkg::OFS_BUFFER || a == nvm_access_pkg::OFS_TABLE_PTR ||
           a == nvm_access_pkg::OFS_IRQ_STATUS || a == nvm_access_pkg::OFS_IRQ_MASK;
  endfunction

  // Write path takes address and data together, one write in flight
  wire wrTake = awvalid && wvalid && !bvalid_reg;
  wire lane0 = wrTake && wstrb[0];
  wire wrCtrl = lane0 && awaddr == nvm_access_pkg::OFS_CONTROL;
  wire wrIndex = lane0 && awaddr == nvm_access_pkg::OFS_INDEX;
  wire wrBuffer = lane0 && awaddr == nvm_access_pkg::OFS_BUFFER;
  wire wrTptr = wrTake && awaddr == nvm_access_pkg::OFS_TABLE_PTR;
  wire wrStat = lane0 && awaddr == nvm_access_pkg::OFS_IRQ_STATUS;
  wire wrMask = lane0 && awaddr == nvm_access_pkg::OFS_IRQ_MASK;
  wire rdTake = arvalid && !rvalid_reg;
  wire busy = state_reg != nvm_access_pkg::ST_IDLE;
  wire dataSpace = !ctrl_reg.memSel && !ctrl_reg.cfgSel;
  wire [7:0] wByte = wdata[7:0];
  wire progReq = wrCtrl && wByte[nvm_access_pkg::BIT_PROG] && !busy;
  // A trigger without permit is an improper attempt: no cycle, fault raised
  wire progStart = progReq && ctrl_reg.permit;
  wire progImproper = progReq && !ctrl_reg.permit;
  // Fetch only when the data EEPROM is selected, by the bits as they stand
  wire fetchStart = wrCtrl && wByte[nvm_access_pkg::BIT_FETCH] && dataSpace && !busy;
  wire doFetch = ctrl_reg.fetchTrig;
  wire countDone = count_reg == 32'(PROG_CYCLES - 1);
  wire progFinish = state_reg == nvm_access_pkg::ST_DONE;
  wire eraseOp = ctrl_reg.rowErase && !ctrl_reg.cfgSel && ctrl_reg.memSel;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      nvm_access_pkg::ST_IDLE: begin
        if (progStart) begin
          state_next = nvm_access_pkg::ST_PROG;
        end
      end
      nvm_access_pkg::ST_PROG: begin
        if (countDone) begin
          state_next = nvm_access_pkg::ST_DONE;
        end
      end
      nvm_access_pkg::ST_DONE: begin
        state_next = nvm_access_pkg::ST_IDLE;
      end
      default: begin
        state_next = nvm_access_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    // Control is frozen while a cycle runs so the target cannot shift under it
    if (wrCtrl && !busy) begin
      ctrl_next.memSel = wByte[nvm_access_pkg::BIT_MEM_SEL];
      ctrl_next.cfgSel = wByte[nvm_access_pkg::BIT_CFG_SEL];
      ctrl_next.rowErase = wByte[nvm_access_pkg::BIT_ROW_ERASE];
      ctrl_next.fault = wByte[nvm_access_pkg::BIT_FAULT];
      ctrl_next.permit = wByte[nvm_access_pkg::BIT_PERMIT];
    end
    if (progStart) begin
      ctrl_next.progTrig = 1'b1;
    end
    if (fetchStart) begin
      ctrl_next.fetchTrig = 1'b1;
    end
    if (doFetch) begin
      ctrl_next.fetchTrig = 1'b0;
    end
    if (progImproper) begin
      ctrl_next.fault = 1'b1;
    end
    if (progFinish) begin
      ctrl_next.progTrig = 1'b0;
      ctrl_next.rowErase = 1'b0;
      ctrl_next.fault = 1'b0;
    end
  end

  always_comb begin
    buffer_next = buffer_reg;
    if (wrBuffer && !busy) begin
      buffer_next = wByte;
    end
    if (doFetch) begin
      buffer_next = eeprom[index_reg];
    end
  end

  // Set wins over a write-one clear
  always_comb begin
    irqStat_next = irqStat_reg;
    if (wrStat) begin
      irqStat_next = irqStat_reg & ~wByte[nvm_access_pkg::IRQ_W-1:0];
    end
    if (progFinish) begin
      irqStat_next[nvm_access_pkg::IRQ_DONE] = 1'b1;
    end
    if (progImproper) begin
      irqStat_next[nvm_access_pkg::IRQ_FAULT] = 1'b1;
    end
  end

  // Fault is unknown after power-up, like the state of the cycle it reports
  // A reset that cuts a cycle sets the fault, and a long reset keeps it set
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= nvm_access_pkg::CTRL_RESET;
      ctrl_reg.memSel <= ctrl_reg.memSel;
      ctrl_reg.cfgSel <= ctrl_reg.cfgSel;
      ctrl_reg.fault <= busy || (ctrl_reg.fault && rstPrev_reg);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Not reset: high on every edge of a reset but its first
  always_ff @(posedge clk) begin
    rstPrev_reg <= srst;
  end

  // Gray order along idle, program, done
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= nvm_access_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Counts the cycles spent in the program state
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= '0;
    end else begin
      count_reg <= (state_reg == nvm_access_pkg::ST_PROG) ? count_reg + 32'h1 : '0;
    end
  end

  // Index and pointer are locked while a cycle runs, and so are software writes to the buffer
  always_ff @(posedge clk) begin
    if (srst) begin
      index_reg <= '0;
    end else if (wrIndex && !busy) begin
      index_reg <= wByte;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      buffer_reg <= '0;
    end else begin
      buffer_reg <= buffer_next;
    end
  end

  // Merged as a whole word, then cut to the pointer width
  wire [31:0] tptrMerged = strobeMerge(32'(tptr_reg), wdata, wstrb);
  always_ff @(posedge clk) begin
    if (srst) begin
      tptr_reg <= '0;
    end else if (wrTptr && !busy) begin
      tptr_reg <= tptrMerged[nvm_access_pkg::TPTR_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irqStat_reg <= '0;
    end else begin
      irqStat_reg <= irqStat_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irqMask_reg <= '0;
    end else if (wrMask) begin
      irqMask_reg <= wByte[nvm_access_pkg::IRQ_W-1:0];
    end
  end

  // Array is not reset: it stands for nonvolatile content
  always_ff @(posedge clk) begin
    if (progFinish && dataSpace) begin
      eeprom[index_reg] <= buffer_reg;
    end
  end

  wire [7:0] ctrlRead = {ctrl_reg.memSel, ctrl_reg.cfgSel, 1'b0, ctrl_reg.rowErase,
                         ctrl_reg.fault, ctrl_reg.permit, ctrl_reg.progTrig,
                         ctrl_reg.fetchTrig};
  wire [31:0] readMux =
    (araddr == nvm_access_pkg::OFS_CONTROL) ? {24'h0, ctrlRead} :
    (araddr == nvm_access_pkg::OFS_INDEX) ? {24'h0, index_reg} :
    (araddr == nvm_access_pkg::OFS_BUFFER) ? {24'h0, buffer_reg} :
    (araddr == nvm_access_pkg::OFS_TABLE_PTR) ? 32'(tptr_reg) :
    (araddr == nvm_access_pkg::OFS_IRQ_STATUS) ? 32'(irqStat_reg) :
    (araddr == nvm_access_pkg::OFS_IRQ_MASK) ? 32'(irqMask_reg) : 32'h0;

  // One answer at a time: the next request waits until this answer is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= nvm_access_pkg::RESP_OKAY;
    end else if (wrTake) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= isMapped(awaddr) ? nvm_access_pkg::RESP_OKAY : nvm_access_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read data is captured at the take, so it stands unchanged until rready
  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= nvm_access_pkg::RESP_OKAY;
      rdata_reg <= '0;
    end else if (rdTake) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= readMux;
      rresp_reg <= isMapped(araddr) ? nvm_access_pkg::RESP_OKAY : nvm_access_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Ready is combinational: a write is taken at the first edge both halves stand with no write answer pending
  assign awready = wrTake;
  assign wready = wrTake;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = rdTake;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign progBusy = busy;
  assign flashEraseStrobe = progFinish && eraseOp;
  assign flashRowAddr = tptr_reg;
  assign irq = |(irqStat_reg & irqMask_reg);
endmodule // eeprom_access_control

/* File: eeprom_access_control_props.sv */
// Concurrent checks on the register bus and program cycle of the access block.
// Bound into the access control module; sees its ports only.
`timescale 1ns/10ps
module eeprom_access_control_props #(
  parameter int PROG_CYCLES = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic progBusy,
  input wire logic flashEraseStrobe
);
  localparam int BUSY_MAX = PROG_CYCLES + 1;
  logic [7:0] rdAddr_reg;
  // Read data carries no address, so remember the one taken
  always_ff @(posedge clk) if (arvalid && arready) rdAddr_reg <= araddr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_AW_TAKE: assert property (awready == (awvalid && wvalid && !bvalid))
    else $error("write ready mismatch");
  AST_AR_TAKE: assert property (arready == (arvalid && !rvalid)) else $error("read ready mismatch");
  AST_B_ANSWER: assert property (awvalid && awready |=> bvalid) else $error("no write answer");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  AST_BIT_FIVE: assert property (rvalid && rdAddr_reg == nvm_access_pkg::OFS_CONTROL |->
    rdata[5] == 1'b0) else $error("control bit 5 set");
  AST_INDEX_W: assert property (rvalid && rdAddr_reg == nvm_access_pkg::OFS_INDEX |->
    rdata[31:8] == 24'h0) else $error("index wider than 8 bits");
  AST_BUSY_END: assert property ($rose(progBusy) |=> progBusy ##[1:BUSY_MAX] !progBusy)
    else $error("program cycle length wrong");
  AST_ERASE_END: assert property (flashEraseStrobe |-> progBusy ##1 !progBusy)
    else $error("erase strobe outside cycle end");
endmodule // eeprom_access_control_props

bind eeprom_access_control eeprom_access_control_props #(.PROG_CYCLES(PROG_CYCLES)) props (
  .clk, .srst, .awvalid, .awready, .wvalid, .bresp, .bvalid, .bready, .araddr, .arvalid,
  .arready, .rdata, .rresp, .rvalid, .rready, .progBusy, .flashEraseStrobe);

/* File: nvm_access_pkg.sv */
// Constants, field layout and types for the nonvolatile access control block.
// Assumes an AXI4-Lite master with 32-bit data and a 250 MHz system clock.
// What this block does
// - With the memory-space select bit clear, accesses go to the data EEPROM; set, to program Flash.
// - With the configuration-space select bit set, accesses go to configuration space instead.
// - The location index is 8 bits and picks one of 256 EEPROM bytes, 00h to FFh.
// - Control bit 5 is unimplemented, ignores writes and reads zero.
// - With row erase set and program Flash selected, the next program trigger erases the Flash row at the table pointer.
// - The program fault flag is set by a reset during programming or an improper write attempt.
// - The program fault flag reads zero after a write that completed normally.
// - A program fault leaves the memory-space and configuration-space selects untouched.
// - Erase and write cycles run only while the program permit bit is one.
// - Software can only set the program trigger; writing zero to it does nothing.
// - Hardware clears the program trigger when the erase or write cycle completes.
// - The fetched byte is in the byte buffer on the second cycle after the fetch write, one cycle behind the fetch trigger bit.
// - The byte buffer keeps its value until another read or a software write to it.
package nvm_access_pkg;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INDEX = 8'h04;
  localparam logic [7:0] OFS_BUFFER = 8'h08;
  localparam logic [7:0] OFS_TABLE_PTR = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam int BIT_MEM_SEL = 7;
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_FAULT = 3;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_PROG = 1;
  localparam int BIT_FETCH = 0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_W = 2;
  localparam int TPTR_W = 22;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PROG_CYCLES_DEF = 16;

  typedef struct packed {
    logic memSel;
    logic cfgSel;
    logic rowErase;
    logic fault;
    logic permit;
    logic progTrig;
    logic fetchTrig;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{default: 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_DONE = 2'b11
  } prog_state_t;
endpackage

/* File: test_eeprom_access_control.sv */
// Register-level bench for the EEPROM access control block.
// Drives the AXI4-Lite port itself; no far-side model is needed.
`timescale 1ns/10ps
module test_eeprom_access_control;
  // Short program cycle keeps the run brief; checks assume it outlasts a write and a read yet ends within the 20-clock erase wait
  // Long enough for a control write and a read to land inside one cycle
  localparam int PROG = 12;
  localparam logic [7:0] CT = nvm_access_pkg::OFS_CONTROL, IX = nvm_access_pkg::OFS_INDEX,
    BF = nvm_access_pkg::OFS_BUFFER, TP = nvm_access_pkg::OFS_TABLE_PTR,
    ST = nvm_access_pkg::OFS_IRQ_STATUS, MK = nvm_access_pkg::OFS_IRQ_MASK;
  logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, progBusy, flashEraseStrobe, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rrv;
  logic [21:0] flashRowAddr;
  int fails = 0;
  int total_checks = 0;
  eeprom_access_control #(.PROG_CYCLES(PROG)) dut (.clk, .srst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .progBusy, .flashEraseStrobe, .flashRowAddr, .irq);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rdv = rdata;
    rrv = rresp;
    rready <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    stop_test();
  end
  initial begin
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // Selects and fault are unknown after power-up
    rd(CT); chk("ctrl reset", rdv & 32'h37, 32'h0);
    rd(IX); chk("index reset", rdv, 32'h0);
    rd(8'h18); chk("unmapped", {rrv, rdv[29:0]}, {nvm_access_pkg::RESP_SLVERR, 30'h0});
    wr(CT, 32'he0); rd(CT); chk("ctrl bit5", rdv, 32'hc0);
    // Trigger without permit: refused, fault raised, selects kept for tracing
    wr(CT, 32'hc2); rd(CT); chk("fault selects", rdv, 32'hc8);
    chk("no cycle", progBusy, 1'b0);
    rd(ST); chk("fault status", rdv, 32'h2);
    chk("irq masked", irq, 1'b0);
    wr(MK, 32'h3); chk("irq raised", irq, 1'b1);
    wr(ST, 32'h2); chk("irq cleared", irq, 1'b0);
    wr(IX, 32'hff); wr(BF, 32'ha5); wr(CT, 32'h0c); wr(CT, 32'h0e);
    chk("cycle running", progBusy, 1'b1);
    wr(CT, 32'h04);
    rd(CT);
    chk("trigger kept", rdv, 32'h0e);
    rdv = '1;
    for (int i = 0; i < 20 && rdv[1] !== 1'b0; i++) rd(CT);
    chk("ctrl done", rdv, 32'h04);
    rd(ST); chk("done status", rdv, 32'h1);
    chk("irq done", irq, 1'b1);
    wr(ST, 32'h1);
    wr(CT, 32'h04); chk("zero trigger", progBusy, 1'b0);
    wr(BF, 32'h0);
    wr(CT, 32'h05);
    rd(BF); chk("fetched byte", rdv, 32'ha5);
    rd(CT); chk("fetch cleared", rdv, 32'h04);
    wr(IX, 32'h0); rd(BF); chk("buffer kept", rdv, 32'ha5);
    wr(CT, 32'h84); wr(BF, 32'h11); wr(CT, 32'h85);
    rd(BF); chk("flash fetch", rdv, 32'h11);
    wr(TP, 32'h3abcde); wr(CT, 32'h94); wr(CT, 32'h96);
    for (int i = 0; i < 20 && flashEraseStrobe !== 1'b1; i++) @(posedge clk);
    chk("erase strobe", flashEraseStrobe, 1'b1);
    chk("erase row", flashRowAddr, 32'h3abcde);
    rdv = '1;
    for (int i = 0; i < 20 && rdv[1] !== 1'b0; i++) rd(CT);
    chk("erase cleared", rdv, 32'h84);
    // Reset in mid-cycle: the cut cycle leaves the fault set and the selects kept
    wr(CT, 32'h44);
    wr(CT, 32'h46);
    chk("cut cycle running", progBusy, 1'b1);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(CT);
    chk("cut cycle fault", rdv, 32'h48);
    chk("cut cycle ended", progBusy, 1'b0);
    stop_test();
  end
endmodule // test_eeprom_access_control
